// ==== hdl/fsc_counters.sv ====
// Module: frame-sync and far-end block error counters with host read port
`timescale 1ns/1ps

// Summary of operation
// - T1: count multiframes spent out of sync
// - Multiframe counting continues while sync lost
// - T1 F-bit: Ft in D4, FPS in ESF
// - F-bit counting halts while sync lost
// - Framing mode plus select choose source
// - E1: count FAS word errors
// - E1: no count while sync lost
// - E1: ignore FAS errors while hunting
// - Sync-loss count: high byte 46, low 47
// - E-bit counter works only in E1
// - E-bits from frames 13, 15 CRC-4
// - Count each received zero E-bit
// - E-bit halts on FAS/CRC-4 loss only
// - E-bit count: high byte 48, low 49
// - Select one: multiframes, zero: F-bit errors
// - Latch counts per second or fast period
// - Manual latch on rising update bit
module fsc_counters
	import fsc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Configuration
	input wire logic e1_mode,
	input wire logic framing_mode_select,
	input wire logic count_function_select,
	input wire logic counter_update_rate_select,
	input wire logic manual_update_enable,
	input wire logic manual_counter_latch,
	// Receive framer events (one-cycle pulses) and status levels
	input wire logic frame_tick,
	input wire logic multiframe_tick,
	input wire logic receive_sync_lost_flag,
	input wire logic t1_ft_error,
	input wire logic t1_fps_error,
	input wire logic e1_fas_word_error,
	input wire logic fas_hunting,
	input wire logic cas_mf_hunting,
	input wire logic crc4_mf_hunting,
	input wire logic crc4_mf_enabled,
	input wire logic ebit_valid,
	input wire logic ebit_value,
	// Host read port
	input wire logic [7:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	// Latch pulse for observation
	output logic counts_latched
);

	// ==========================================
	// Internal state
	logic [15:0] sync_loss_counter; // Running count
	logic [15:0] far_end_error_counter; // Running count
	logic [15:0] sync_loss_snap; // Host-visible copy
	logic [15:0] far_end_snap; // Host-visible copy
	logic [13:0] frame_cnt; // Frames since last latch
	logic [13:0] period_frames; // Current latch period
	logic manual_prev; // Previous manual bit
	logic sync_inc; // Sync-loss counter increment
	logic ebit_inc; // E-bit counter increment
	logic auto_latch; // Period expired
	logic manual_latch; // Manual rising edge
	logic do_latch; // Any latch this cycle
	logic host_wr_seen; // Writes have no effect here

	// ==========================================
	// Sync-loss count source selection
	always_comb begin
		sync_inc = 1'b0;
		if (e1_mode) begin
			// Hunting at any level blocks FAS error counting
			sync_inc = e1_fas_word_error && !receive_sync_lost_flag
				&& !fas_hunting && !cas_mf_hunting && !crc4_mf_hunting;
		end else if (count_function_select) begin
			// Out-of-sync multiframes: counted only while sync is lost
			sync_inc = multiframe_tick && receive_sync_lost_flag;
		end else begin
			// F-bit: D4 takes Ft errors, ESF takes FPS errors
			sync_inc = !receive_sync_lost_flag
				&& (framing_mode_select ? t1_fps_error : t1_ft_error);
		end
	end

	// ==========================================
	// E-bit source: only E1, CRC-4 multiframe, not on FAS/CRC-4 loss
	assign ebit_inc = e1_mode && crc4_mf_enabled && ebit_valid
		&& !ebit_value
		&& !fas_hunting && !crc4_mf_hunting;

	// ==========================================
	// Update period: fast rate depends on line type
	assign period_frames = !counter_update_rate_select ? ONE_SEC_FRAMES
		: (e1_mode ? E1_FAST_FRAMES : T1_FAST_FRAMES);
	assign auto_latch = !manual_update_enable && frame_tick
		&& (frame_cnt >= period_frames - 14'd1);
	assign manual_latch = manual_update_enable && manual_counter_latch && !manual_prev;
	assign do_latch = auto_latch || manual_latch;
	// Host writes are accepted and discarded
	assign host_wr_seen = host_wr && (host_wdata != 8'h00);

	// ==========================================
	// Frame counter for the latch period
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			frame_cnt <= 14'd0;
		end else if (do_latch) begin
			frame_cnt <= 14'd0;
		end else if (frame_tick) begin
			frame_cnt <= frame_cnt + 14'd1;
		end
	end

	// ==========================================
	// Manual bit edge tracker
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			manual_prev <= 1'b0;
		end else begin
			manual_prev <= manual_counter_latch;
		end
	end

	// ==========================================
	// Running counters; an event in the latch cycle starts the new period
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_loss_counter <= COUNT_RESET;
			far_end_error_counter <= COUNT_RESET;
		end else if (do_latch) begin
			sync_loss_counter <= {15'd0, sync_inc};
			far_end_error_counter <= {15'd0, ebit_inc};
		end else begin
			// Saturate rather than wrap; unreachable in a normal period
			if (sync_inc && sync_loss_counter != 16'hFFFF) begin
				sync_loss_counter <= sync_loss_counter + 16'd1;
			end
			if (ebit_inc && far_end_error_counter != 16'hFFFF) begin
				far_end_error_counter <= far_end_error_counter + 16'd1;
			end
		end
	end

	// ==========================================
	// Snapshot registers seen by the host
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync_loss_snap <= COUNT_RESET;
			far_end_snap <= COUNT_RESET;
			counts_latched <= 1'b0;
		end else begin
			counts_latched <= do_latch;
			if (do_latch) begin
				sync_loss_snap <= sync_loss_counter;
				far_end_snap <= far_end_counter_view();
			end
		end
	end

	// E-bit snapshot is zero in T1
	function automatic logic [15:0] far_end_counter_view();
		far_end_counter_view = e1_mode ? far_end_error_counter : COUNT_RESET;
	endfunction : far_end_counter_view

	// ==========================================
	// Host read mux, registered; both bytes from one snapshot
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			host_rdata <= RDATA_RESET;
		end else if (host_rd) begin
			case (host_addr)
				SYNC_LOSS_COUNT_HIGH_OFS: host_rdata <= sync_loss_snap[15:8];
				SYNC_LOSS_COUNT_LOW_OFS: host_rdata <= sync_loss_snap[7:0];
				FAR_END_ERROR_COUNT_HIGH_OFS: host_rdata <= far_end_snap[15:8];
				FAR_END_ERROR_COUNT_LOW_OFS: host_rdata <= far_end_snap[7:0];
				default: host_rdata <= RDATA_RESET; // Unmapped reads zero
			endcase
		end
	end

	// ==========================================
	// Checks
	sequence s_manual_rise;
		manual_update_enable && manual_counter_latch && !manual_prev;
	endsequence

	// ==========================================
	// Building blocks for the counting checks
	// One step up of the sync-loss count since the last edge
	sequence s_sync_step;
		sync_loss_counter == $past(sync_loss_counter) + 16'd1;
	endsequence
	// Ft error in D4 with F-bit counting, sync held, room left
	sequence s_d4_ft_event;
		!e1_mode && !count_function_select && !framing_mode_select && t1_ft_error
			&& !receive_sync_lost_flag && !do_latch && sync_loss_counter != 16'hFFFF;
	endsequence
	// FPS error in ESF with F-bit counting, sync held, room left
	sequence s_esf_fps_event;
		!e1_mode && !count_function_select && framing_mode_select && t1_fps_error
			&& !receive_sync_lost_flag && !do_latch && sync_loss_counter != 16'hFFFF;
	endsequence
	// Alignment word error in E1 with every synchroniser level locked
	sequence s_fas_event;
		e1_mode && e1_fas_word_error && !receive_sync_lost_flag && !fas_hunting
			&& !cas_mf_hunting && !crc4_mf_hunting && !do_latch && sync_loss_counter != 16'hFFFF;
	endsequence
	// Zero E-bit that arrives while only the CAS level is hunting
	sequence s_ebit_cas_only;
		e1_mode && crc4_mf_enabled && ebit_valid && !ebit_value && cas_mf_hunting
			&& !fas_hunting && !crc4_mf_hunting && !do_latch && far_end_error_counter != 16'hFFFF;
	endsequence

	a_manual_latch_next: assert property (@(posedge ref_clk) disable iff (srst)
		s_manual_rise |=> counts_latched && sync_loss_snap == $past(sync_loss_counter))
		else $error("manual latch did not capture count");
	a_oos_counts_lost: assert property (@(posedge ref_clk) disable iff (srst)
		!e1_mode && count_function_select && multiframe_tick && receive_sync_lost_flag && !do_latch
		&& sync_loss_counter != 16'hFFFF |=> sync_loss_counter == $past(sync_loss_counter) + 16'd1)
		else $error("out-of-sync multiframe not counted");
	a_fbit_halt_lost: assert property (@(posedge ref_clk) disable iff (srst)
		!e1_mode && !count_function_select && receive_sync_lost_flag && !do_latch
		|=> $stable(sync_loss_counter))
		else $error("F-bit counted during sync loss");
	a_e1_halt_lost: assert property (@(posedge ref_clk) disable iff (srst)
		e1_mode && receive_sync_lost_flag && !do_latch |=> $stable(sync_loss_counter))
		else $error("E1 counted during sync loss");
	a_e1_hunt_ignore: assert property (@(posedge ref_clk) disable iff (srst)
		e1_mode && (fas_hunting || cas_mf_hunting || crc4_mf_hunting) && !do_latch
		|=> $stable(sync_loss_counter))
		else $error("FAS error counted while hunting");
	a_ebit_t1_zero: assert property (@(posedge ref_clk) disable iff (srst)
		!e1_mode && !do_latch |=> $stable(far_end_error_counter))
		else $error("E-bit counter moved in T1");
	a_ebit_zero_count: assert property (@(posedge ref_clk) disable iff (srst)
		e1_mode && crc4_mf_enabled && ebit_valid && !ebit_value && !fas_hunting && !crc4_mf_hunting
		&& !do_latch && far_end_error_counter != 16'hFFFF
		|=> far_end_error_counter == $past(far_end_error_counter) + 16'd1)
		else $error("zero E-bit not counted");
	a_ebit_cas_keeps: assert property (@(posedge ref_clk) disable iff (srst)
		s_ebit_cas_only |=> far_end_error_counter == $past(far_end_error_counter) + 16'd1)
		else $error("E-bit gating wrong on CAS loss");
	a_read_high_byte: assert property (@(posedge ref_clk) disable iff (srst)
		host_rd && host_addr == SYNC_LOSS_COUNT_HIGH_OFS |=> host_rdata == $past(sync_loss_snap[15:8]))
		else $error("sync-loss high byte wrong");
	a_write_ignored: assert property (@(posedge ref_clk) disable iff (srst)
		host_wr_seen && !do_latch |=> $stable(sync_loss_snap) && $stable(far_end_snap))
		else $error("write changed snapshot");

	// ==========================================
	// Counting sources in each mode
	a_d4_ft_count: assert property (@(posedge ref_clk) disable iff (srst)
		s_d4_ft_event |=> s_sync_step)
		else $error("Ft error not counted in D4");
	a_esf_fps_count: assert property (@(posedge ref_clk) disable iff (srst)
		s_esf_fps_event |=> s_sync_step)
		else $error("FPS error not counted in ESF");
	a_fas_error_count: assert property (@(posedge ref_clk) disable iff (srst)
		s_fas_event |=> s_sync_step)
		else $error("alignment word error not counted");
	// E-bit counter gating: CRC-4 multiframe only, halted while FAS or CRC-4 multiframe hunting
	a_ebit_crc4_only: assert property (@(posedge ref_clk) disable iff (srst)
		!crc4_mf_enabled && !do_latch |=> $stable(far_end_error_counter))
		else $error("E-bit counted without CRC-4 multiframe");
	a_ebit_hunt_halt: assert property (@(posedge ref_clk) disable iff (srst)
		(fas_hunting || crc4_mf_hunting) && !do_latch |=> $stable(far_end_error_counter))
		else $error("E-bit counted while hunting");
	a_t1_snap_zero: assert property (@(posedge ref_clk) disable iff (srst)
		!e1_mode && do_latch |=> far_end_snap == COUNT_RESET)
		else $error("E-bit snapshot not zero in T1");
	// ==========================================
	// Latch instants, stated from the period constants
	a_fast_e1_latch: assert property (@(posedge ref_clk) disable iff (srst)
		!manual_update_enable && counter_update_rate_select && e1_mode && frame_tick
		&& frame_cnt == E1_FAST_FRAMES - 14'd1 |=> counts_latched)
		else $error("fast E1 latch missed");
	a_fast_t1_latch: assert property (@(posedge ref_clk) disable iff (srst)
		!manual_update_enable && counter_update_rate_select && !e1_mode && frame_tick
		&& frame_cnt == T1_FAST_FRAMES - 14'd1 |=> counts_latched)
		else $error("fast T1 latch missed");
	a_slow_latch: assert property (@(posedge ref_clk) disable iff (srst)
		!manual_update_enable && !counter_update_rate_select && frame_tick
		&& frame_cnt == ONE_SEC_FRAMES - 14'd1 |=> counts_latched)
		else $error("one-second latch missed");
	// Manual mode: only a rising bit may latch
	a_manual_no_auto: assert property (@(posedge ref_clk) disable iff (srst)
		manual_update_enable && !(manual_counter_latch && !manual_prev) |=> !counts_latched)
		else $error("latch without manual rise");
	// Running counts restart from zero, or one if an event shared the edge
	a_latch_restart: assert property (@(posedge ref_clk) disable iff (srst)
		counts_latched |-> sync_loss_counter <= 16'h0001 && far_end_error_counter <= 16'h0001)
		else $error("counts not restarted at latch");
	// ==========================================
	// Host port reads and snapshot stability
	a_read_low_byte: assert property (@(posedge ref_clk) disable iff (srst)
		host_rd && host_addr == SYNC_LOSS_COUNT_LOW_OFS |=> host_rdata == $past(sync_loss_snap[7:0]))
		else $error("sync-loss low byte wrong");
	a_far_high_read: assert property (@(posedge ref_clk) disable iff (srst)
		host_rd && host_addr == FAR_END_ERROR_COUNT_HIGH_OFS |=> host_rdata == $past(far_end_snap[15:8]))
		else $error("far-end high byte wrong");
	a_far_low_read: assert property (@(posedge ref_clk) disable iff (srst)
		host_rd && host_addr == FAR_END_ERROR_COUNT_LOW_OFS |=> host_rdata == $past(far_end_snap[7:0]))
		else $error("far-end low byte wrong");
	a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (srst)
		host_rd && (host_addr < SYNC_LOSS_COUNT_HIGH_OFS || host_addr > FAR_END_ERROR_COUNT_LOW_OFS)
		|=> host_rdata == RDATA_RESET)
		else $error("unmapped read not zero");
	a_snap_hold: assert property (@(posedge ref_clk) disable iff (srst)
		!do_latch |=> $stable(sync_loss_snap) && $stable(far_end_snap))
		else $error("snapshot moved without a latch");

endmodule : fsc_counters

// ==== common/fsc_pkg.sv ====
// Package: constants for the frame-sync and E-bit error counter block
package fsc_pkg;
	// ==========================================
	// Register offsets (byte-wide host port)
	localparam logic [7:0] SYNC_LOSS_COUNT_HIGH_OFS = 8'h46;
	localparam logic [7:0] SYNC_LOSS_COUNT_LOW_OFS = 8'h47;
	localparam logic [7:0] FAR_END_ERROR_COUNT_HIGH_OFS = 8'h48;
	localparam logic [7:0] FAR_END_ERROR_COUNT_LOW_OFS = 8'h49;
	// ==========================================
	// Reset values
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	// ==========================================
	// Update periods in frames (42 ms = 333 T1 frames, 62.5 ms = 500 E1 frames)
	localparam logic [13:0] T1_FAST_FRAMES = 14'd333;
	localparam logic [13:0] E1_FAST_FRAMES = 14'd500;
	// One second in frames: 8000 frames on both lines
	localparam logic [13:0] ONE_SEC_FRAMES = 14'd8000;
	// ==========================================
	// Counter-update state machine (Gray coded)
	typedef enum logic [1:0] {
		FSC_IDLE = 2'b00,
		FSC_LATCH = 2'b01
	} fsc_upd_e;
endpackage : fsc_pkg

// ==== dv/fsc_line_model.sv ====
// Line-side model: framer event pulses toward the counters
`timescale 1ns/1ps
module fsc_line_model (
	// Clock
	input wire logic ref_clk,
	// Framer events
	output logic frame_tick,
	output logic multiframe_tick,
	output logic t1_ft_error,
	output logic t1_fps_error,
	output logic e1_fas_word_error,
	output logic ebit_valid,
	output logic ebit_value
);
	// All quiet at time zero
	initial begin
		{multiframe_tick, t1_ft_error, t1_fps_error, e1_fas_word_error, ebit_valid, ebit_value, frame_tick} = '0;
	end
	// One frame: events for one cycle, then one quiet cycle
	task automatic frame(input logic [6:0] v);
		@(negedge ref_clk);
		{multiframe_tick, t1_ft_error, t1_fps_error, e1_fas_word_error, ebit_valid, ebit_value, frame_tick} = v;
		@(negedge ref_clk);
		{multiframe_tick, t1_ft_error, t1_fps_error, e1_fas_word_error, ebit_valid, frame_tick} = '0;
		// Stale E-bit never repeats, so it cannot pass for a fresh one
		ebit_value = ~v[1];
	endtask : frame
endmodule : fsc_line_model

// ==== dv/frame_sync_and_ebit_error_counters_tb.sv ====
// Testbench: host reads of sync-loss and far-end error counts
`timescale 1ns/1ps
module frame_sync_and_ebit_error_counters_tb;
	import fsc_pkg::*;
	// ==========================================
	// Signals and event codes {mf, ft, fps, fas, ebv, ebval, frame}
	localparam logic [6:0] MF = 7'h41, FT = 7'h21, FPS = 7'h11, FAS = 7'h09, EB0 = 7'h05, EB1 = 7'h07, FR = 7'h01;
	logic ref_clk = 1'b0, srst = 1'b1, e1_mode = 1'b0, framing_mode_select = 1'b0, count_function_select = 1'b0;
	logic counter_update_rate_select = 1'b0, manual_update_enable = 1'b1, manual_counter_latch = 1'b0;
	logic receive_sync_lost_flag = 1'b0, fas_hunting = 1'b0, cas_mf_hunting = 1'b0, crc4_mf_hunting = 1'b0;
	logic crc4_mf_enabled = 1'b0, host_rd = 1'b0, host_wr = 1'b0, counts_latched;
	logic [7:0] host_addr = 8'h00, host_wdata = 8'h00, host_rdata, d;
	wire logic fr, mf, ft, fps, fas, ebv, ebval;
	int err_total = 0, checks_done = 0, lat_n = 0, n0, n;
	fsc_line_model line_u (.ref_clk(ref_clk), .frame_tick(fr), .multiframe_tick(mf), .t1_ft_error(ft),
		.t1_fps_error(fps), .e1_fas_word_error(fas), .ebit_valid(ebv), .ebit_value(ebval));
	fsc_counters dut_u (.ref_clk(ref_clk), .srst(srst), .e1_mode(e1_mode), .framing_mode_select(framing_mode_select),
		.count_function_select(count_function_select), .counter_update_rate_select(counter_update_rate_select),
		.manual_update_enable(manual_update_enable), .manual_counter_latch(manual_counter_latch), .frame_tick(fr),
		.multiframe_tick(mf), .receive_sync_lost_flag(receive_sync_lost_flag), .t1_ft_error(ft), .t1_fps_error(fps),
		.e1_fas_word_error(fas), .fas_hunting(fas_hunting), .cas_mf_hunting(cas_mf_hunting),
		.crc4_mf_hunting(crc4_mf_hunting), .crc4_mf_enabled(crc4_mf_enabled), .ebit_valid(ebv), .ebit_value(ebval),
		.host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .counts_latched(counts_latched));
	// 25 MHz clock
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// Latch pulses counted at the sampling edge
	always @(posedge ref_clk) begin
		if (counts_latched === 1'b1) lat_n++;
	end
	// ==========================================
	// Shared tasks
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Read: strobe one cycle, sample well after the answer settles
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge ref_clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge ref_clk);
		host_rd = 1'b0;
		@(negedge ref_clk);
		q = host_rdata;
	endtask : rd
	task automatic rd16(input logic [7:0] a, input logic [15:0] exp, input string nm);
		logic [7:0] h, l;
		rd(a, h);
		rd(a + 8'h01, l);
		chk(nm, exp, {h, l});
		$display("Test %s done", nm);
	endtask : rd16
	// Manual latch on a rising bit, bounded wait for the pulse
	task automatic latch();
		n0 = lat_n;
		@(negedge ref_clk);
		manual_counter_latch = 1'b1;
		for (n = 0; n < 20 && lat_n == n0; n++) @(negedge ref_clk);
		manual_counter_latch = 1'b0;
		if (n == 20) begin
			err_total++;
			print_verdict();
		end
		@(negedge ref_clk);
	endtask : latch
	// Automatic latch: none after f frames, exactly one with the next frame
	task automatic auto_chk(input int f, input string nm);
		n0 = lat_n;
		repeat (f) line_u.frame(FR);
		repeat (4) @(negedge ref_clk);
		chk(nm, 16'(n0), 16'(lat_n));
		line_u.frame(FR);
		repeat (4) @(negedge ref_clk);
		chk(nm, 16'(n0 + 1), 16'(lat_n));
		$display("Test %s done", nm);
	endtask : auto_chk
	// ==========================================
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		srst = 1'b0;
		rd16(SYNC_LOSS_COUNT_HIGH_OFS, COUNT_RESET, "sync_rst");
		rd16(FAR_END_ERROR_COUNT_HIGH_OFS, COUNT_RESET, "febe_rst");
		rd(8'h50, d);
		chk("unmapped", 16'h0000, {8'h00, d});
		// T1 out-of-sync multiframes in D4 then ESF, only while sync is lost
		count_function_select = 1'b1;
		for (int m = 0; m < 2; m++) begin
			framing_mode_select = m[0];
			receive_sync_lost_flag = 1'b1;
			latch();
			repeat (3) line_u.frame(MF);
			line_u.frame(FT);
			receive_sync_lost_flag = 1'b0;
			line_u.frame(MF);
			latch();
			rd16(SYNC_LOSS_COUNT_HIGH_OFS, 16'h0003, "t1_oos");
		end
		// T1 pattern errors for D4 then ESF; E-bits ignored in T1
		count_function_select = 1'b0;
		crc4_mf_enabled = 1'b1;
		for (int m = 0; m < 2; m++) begin
			framing_mode_select = m[0];
			latch();
			repeat (2) line_u.frame(m ? FPS : FT);
			line_u.frame(m ? FT : FPS);
			line_u.frame(MF);
			line_u.frame(EB0);
			receive_sync_lost_flag = 1'b1;
			line_u.frame(m ? FPS : FT);
			receive_sync_lost_flag = 1'b0;
			latch();
			rd16(SYNC_LOSS_COUNT_HIGH_OFS, 16'h0002, "t1_fbit");
			rd16(FAR_END_ERROR_COUNT_HIGH_OFS, 16'h0000, "t1_febe");
		end
		// E1 alignment word errors and E-bits under each hunt state
		e1_mode = 1'b1;
		latch();
		repeat (2) line_u.frame(FAS);
		line_u.frame(EB0);
		line_u.frame(EB1);
		// Without a CRC-4 multiframe a zero E-bit is not a block error
		crc4_mf_enabled = 1'b0;
		line_u.frame(EB0);
		crc4_mf_enabled = 1'b1;
		receive_sync_lost_flag = 1'b1;
		line_u.frame(FAS);
		receive_sync_lost_flag = 1'b0;
		cas_mf_hunting = 1'b1;
		line_u.frame(FAS);
		line_u.frame(EB0);
		cas_mf_hunting = 1'b0;
		fas_hunting = 1'b1;
		line_u.frame(FAS);
		line_u.frame(EB0);
		fas_hunting = 1'b0;
		crc4_mf_hunting = 1'b1;
		line_u.frame(EB0);
		line_u.frame(FAS);
		crc4_mf_hunting = 1'b0;
		latch();
		rd16(SYNC_LOSS_COUNT_HIGH_OFS, 16'h0002, "e1_fas");
		rd16(FAR_END_ERROR_COUNT_HIGH_OFS, 16'h0002, "e1_febe");
		// Snapshot holds against new counts and host writes
		line_u.frame(FAS);
		@(negedge ref_clk);
		host_addr = SYNC_LOSS_COUNT_LOW_OFS;
		host_wdata = 8'hA5;
		host_wr = 1'b1;
		@(negedge ref_clk);
		host_wr = 1'b0;
		rd16(SYNC_LOSS_COUNT_HIGH_OFS, 16'h0002, "snapshot");
		// Automatic fast latch: align to a period boundary first, bounded
		manual_update_enable = 1'b0;
		counter_update_rate_select = 1'b1;
		n0 = lat_n;
		for (n = 0; n < 600 && lat_n == n0; n++) begin
			line_u.frame(FR);
			repeat (3) @(negedge ref_clk);
		end
		if (n == 600) begin
			err_total++;
			print_verdict();
		end
		// E1 fast period of 500 frames, two of them with alignment errors
		repeat (2) line_u.frame(FAS);
		auto_chk(497, "e1_fast");
		rd16(SYNC_LOSS_COUNT_HIGH_OFS, 16'h0002, "e1_auto");
		// T1 fast period of 333 frames, then the one-second period
		e1_mode = 1'b0;
		auto_chk(332, "t1_fast");
		counter_update_rate_select = 1'b0;
		auto_chk(7999, "one_sec");
		// Manual mode keeps the automatic latch off
		manual_update_enable = 1'b1;
		counter_update_rate_select = 1'b1;
		n0 = lat_n;
		repeat (340) line_u.frame(FR);
		repeat (4) @(negedge ref_clk);
		chk("manual_only", 16'(n0), 16'(lat_n));
		$display("Test manual_only done");
		print_verdict();
	end
endmodule : frame_sync_and_ebit_error_counters_tb
